// [spi_boot_map.svh]
// Purpose: offsets, pin positions, waveform codes and timing counts for the flash boot reader
// Assumes: 125 MHz node clock, 18-bit words
// Notes: definitions only
`ifndef SPI_BOOT_MAP_SVH
`define SPI_BOOT_MAP_SVH
`define SPI_DIN_BIT 17
`define SPI_DOUT_BIT 3
`define SPI_CLK_BIT 1
`define SPI_SEL_BIT 5
`define SPI_PIN_COUNT 18
`define SPI_WORD_W 18
`define SPI_CMD_W 32
`define SPI_READ_OPCODE 8'h03
`define SPI_COLD_ADDR 24'h000000
`define SPI_WAVE_LOW 3'b000
`define SPI_WAVE_CLK 3'b001
`define SPI_WAVE_SEL 3'b100
`define SPI_WAVE_SELCLK 3'b101
`define SPI_UNIT_PS 6500
`define SPI_CLK_PS 8000
`define SPI_UNIT_CYC ((`SPI_UNIT_PS + `SPI_CLK_PS - 1) / `SPI_CLK_PS)
`define SPI_MIN_HALF 3
`define SPI_FIFO_DEPTH 16
`define SPI_HDR_DEST 2'd0
`define SPI_HDR_COUNT 2'd1
`define SPI_HDR_EXEC 2'd2
`define SPI_HDR_DATA 2'd3
`endif

// [spi_boot_pkg.sv]
// Purpose: types shared by the flash boot reader
// Assumes: nothing beyond the map header
// Notes: one-hot state codes
package spi_boot_pkg;
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_SELHI = 7'h02,
		S_CMD = 7'h04,
		S_READ = 7'h08,
		S_WORD = 7'h10,
		S_EXEC = 7'h20,
		S_END = 7'h40
	} boot_state_t;
	typedef logic [2:0] wave_t;
endpackage : spi_boot_pkg

// [boot_fifo.sv]
// Purpose: word buffer between the serial reader and the memory write port
// Assumes: single clock, synchronous reset
// Notes: depth must be a power of two
`timescale 1ns/1ns
module boot_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);
	// pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
		$error("boot_fifo: depth must be a power of two, at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr_q;
	logic [PW-1:0] rdPtr_q;
	logic [PW:0] count_q;
	wire doPush = inValid && inReady;
	wire doPop = outValid && outReady;
	assign inReady = (count_q != (PW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData = mem[rdPtr_q];
	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (doPush) begin
			mem[wrPtr_q] <= inData;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (doPush)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (doPop)
				rdPtr_q <= rdPtr_q + 1'b1;
			if (doPush && !doPop)
				count_q <= count_q + 1'b1;
			else if (doPop && !doPush)
				count_q <= count_q - 1'b1;
		end
	end
endmodule : boot_fifo

// [spi_flash_boot_reader.sv]
// Purpose: serial flash master that streams boot sub-streams into node memory
// Assumes: mode-0 flash, one read command per boot, memory write port with ready
// Notes: pins idle undriven (pulled low) until the first boot request
`timescale 1ns/1ns
`include "spi_boot_map.svh"
module spi_flash_boot_reader #(
	parameter int DELAY_W = 16,
	parameter int ADDR_W = 18,
	parameter int FIFO_DEPTH = `SPI_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic bootStart,
	input wire logic coldStart,
	input wire logic [17:0] cmdItem1,
	input wire logic [17:0] cmdItem2,
	input wire logic [DELAY_W-1:0] halfBitDelay,
	input wire logic [17:0] ioIn,
	output logic [17:0] ioOut,
	output logic [17:0] ioOeN,
	output logic memWrValid,
	input wire logic memWrReady,
	output logic [ADDR_W-1:0] memWrAddr,
	output logic [17:0] memWrData,
	output logic execValid,
	output logic [ADDR_W-1:0] execAddr,
	input wire logic resumeStream,
	input wire logic stopStream,
	output logic busy,
	output spi_boot_pkg::wave_t pinWave
);
	import spi_boot_pkg::*;

	localparam int WW = `SPI_WORD_W;
	localparam int CW = `SPI_CMD_W;
	localparam int HW = DELAY_W + 8;
	localparam int FW = ADDR_W + WW;

	// a header word must carry the whole address; the divider must hold the scaled delay
	if (ADDR_W < 1 || ADDR_W > WW) begin : g_bad_addr
		$error("spi_flash_boot_reader: ADDR_W must be 1..18");
	end
	if (DELAY_W < 2 || DELAY_W > 24) begin : g_bad_delay
		$error("spi_flash_boot_reader: DELAY_W must be 2..24");
	end
	// the buffer itself refuses a depth that is not a power of two
	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("spi_flash_boot_reader: FIFO_DEPTH must be at least 2");
	end

	////////////////////////////////////////////////////////////////
	// which pin of the port carries which waveform trace
	function automatic logic isDriven(input int idx);
		return idx == `SPI_SEL_BIT || idx == `SPI_DOUT_BIT || idx == `SPI_CLK_BIT;
	endfunction : isDriven

	function automatic logic traceOf(input int idx, input wave_t w);
		logic r;
		r = 1'b0;
		if (idx == `SPI_SEL_BIT)
			r = w[2];
		else if (idx == `SPI_DOUT_BIT)
			r = w[1];
		else if (idx == `SPI_CLK_BIT)
			r = w[0];
		return r;
	endfunction : traceOf

	////////////////////////////////////////////////////////////////
	// state
	boot_state_t state_q;
	boot_state_t state_d;
	wave_t wave_q;
	wave_t wave_d;
	logic drive_q;
	logic drive_d;
	logic phase_q;
	logic phase_d;
	logic [CW-1:0] acc_q;
	logic [CW-1:0] acc_d;
	logic [5:0] bitCnt_q;
	logic [5:0] bitCnt_d;
	logic [1:0] hdrIdx_q;
	logic [1:0] hdrIdx_d;
	logic [ADDR_W-1:0] dest_q;
	logic [ADDR_W-1:0] dest_d;
	logic [WW-1:0] remain_q;
	logic [WW-1:0] remain_d;
	logic [ADDR_W-1:0] exec_q;
	logic [ADDR_W-1:0] exec_d;
	logic execValid_q;
	logic execValid_d;
	logic [HW-1:0] halfCnt_q;
	logic dinMeta_q;
	logic dinSync_q;
	logic fifoPush;
	logic fifoReady;
	logic fifoOutValid;
	logic [FW-1:0] fifoOutData;

	////////////////////////////////////////////////////////////////
	// half-bit divider: one-cycle step enable
	wire [HW-1:0] halfScaled = HW'(halfBitDelay) * HW'(`SPI_UNIT_CYC);
	wire [HW-1:0] halfMin = HW'(`SPI_MIN_HALF);
	// floor keeps the two-flop sampling inside one high phase
	wire [HW-1:0] halfLen = (halfScaled < halfMin) ? halfMin : halfScaled;
	wire running = (state_q != S_IDLE);
	wire stepEn = running && (halfCnt_q == '0);

	always_ff @(posedge clk) begin
		if (rst || !running || halfCnt_q == '0)
			halfCnt_q <= halfLen - 1'b1;
		else
			halfCnt_q <= halfCnt_q - 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// data-in synchroniser
	// first flop may go metastable, so only the second one is read
	always_ff @(posedge clk) begin
		if (rst) begin
			dinMeta_q <= 1'b0;
			dinSync_q <= 1'b0;
		end else begin
			dinMeta_q <= ioIn[`SPI_DIN_BIT];
			dinSync_q <= dinMeta_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// decode
	wire [CW-1:0] coldCmd = {`SPI_READ_OPCODE, `SPI_COLD_ADDR};
	wire [CW-1:0] givenCmd = {cmdItem1[17:2], cmdItem2[17:2]};
	wire [CW-1:0] cmdLoad = coldStart ? coldCmd : givenCmd;
	wire outBit = acc_q[CW-1];
	wire [CW-1:0] accShifted = {acc_q[CW-2:0], 1'b0};
	wire [CW-1:0] accSampled = {acc_q[CW-2:0], dinSync_q};
	wire [WW-1:0] wordIn = acc_q[WW-1:0];
	wire lastCmdBit = (bitCnt_q == 6'(CW - 1));
	wire lastWordBit = (bitCnt_q == 6'(WW - 1));
	wire lastData = (remain_q == WW'(1));
	wire [FW-1:0] fifoInData = {dest_q, wordIn};

	////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		state_d = state_q;
		wave_d = wave_q;
		drive_d = drive_q;
		phase_d = phase_q;
		acc_d = acc_q;
		bitCnt_d = bitCnt_q;
		hdrIdx_d = hdrIdx_q;
		dest_d = dest_q;
		remain_d = remain_q;
		exec_d = exec_q;
		execValid_d = 1'b0;
		fifoPush = 1'b0;
		unique case (state_q)
			S_IDLE: begin
				if (bootStart) begin
					drive_d = 1'b1;
					wave_d = `SPI_WAVE_SEL;
					acc_d = cmdLoad;
					bitCnt_d = '0;
					state_d = S_SELHI;
				end
			end
			S_SELHI: begin
				if (stepEn) begin
					// select drops with the first command bit already set up
					wave_d = {1'b0, outBit, 1'b0};
					phase_d = 1'b0;
					state_d = S_CMD;
				end
			end
			S_CMD: begin
				if (stepEn) begin
					if (!phase_q) begin
						wave_d = {1'b0, outBit, 1'b1};
						phase_d = 1'b1;
					end else if (lastCmdBit) begin
						wave_d = `SPI_WAVE_LOW;
						acc_d = accShifted;
						phase_d = 1'b0;
						bitCnt_d = '0;
						hdrIdx_d = `SPI_HDR_DEST;
						state_d = S_READ;
					end else begin
						acc_d = accShifted;
						bitCnt_d = bitCnt_q + 1'b1;
						wave_d = {1'b0, acc_q[CW-2], 1'b0};
						phase_d = 1'b0;
					end
				end
			end
			S_READ: begin
				if (stepEn) begin
					if (!phase_q) begin
						wave_d = `SPI_WAVE_CLK;
						phase_d = 1'b1;
					end else begin
						wave_d = `SPI_WAVE_LOW;
						acc_d = accSampled;
						phase_d = 1'b0;
						if (lastWordBit) begin
							bitCnt_d = '0;
							state_d = S_WORD;
						end else begin
							bitCnt_d = bitCnt_q + 1'b1;
						end
					end
				end
			end
			S_WORD: begin
				// clock parked low here; the flash waits for the next edge
				unique case (hdrIdx_q)
					`SPI_HDR_DEST: begin
						dest_d = wordIn[ADDR_W-1:0];
						hdrIdx_d = `SPI_HDR_COUNT;
						state_d = S_READ;
					end
					`SPI_HDR_COUNT: begin
						remain_d = wordIn;
						hdrIdx_d = `SPI_HDR_EXEC;
						state_d = S_READ;
					end
					`SPI_HDR_EXEC: begin
						exec_d = wordIn[ADDR_W-1:0];
						if (remain_q == '0) begin
							state_d = S_EXEC;
						end else begin
							hdrIdx_d = `SPI_HDR_DATA;
							state_d = S_READ;
						end
					end
					`SPI_HDR_DATA: begin
						if (fifoReady) begin
							fifoPush = 1'b1;
							dest_d = dest_q + 1'b1;
							remain_d = remain_q - 1'b1;
							state_d = lastData ? S_EXEC : S_READ;
						end
					end
				endcase
			end
			S_EXEC: begin
				// branch only once every copied word has reached memory
				execValid_d = !fifoOutValid;
				if (execValid_q && stopStream) begin
					execValid_d = 1'b0;
					state_d = S_END;
				end else if (execValid_q && resumeStream) begin
					execValid_d = 1'b0;
					hdrIdx_d = `SPI_HDR_DEST;
					phase_d = 1'b0;
					bitCnt_d = '0;
					state_d = S_READ;
				end
			end
			S_END: begin
				if (stepEn) begin
					wave_d = `SPI_WAVE_SEL;
					state_d = S_IDLE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= S_IDLE;
			wave_q <= `SPI_WAVE_LOW;
			drive_q <= 1'b0;
			phase_q <= 1'b0;
			execValid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			wave_q <= wave_d;
			drive_q <= drive_d;
			phase_q <= phase_d;
			execValid_q <= execValid_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			acc_q <= '0;
			bitCnt_q <= '0;
			hdrIdx_q <= `SPI_HDR_DEST;
			dest_q <= '0;
			remain_q <= '0;
			exec_q <= '0;
		end else begin
			acc_q <= acc_d;
			bitCnt_q <= bitCnt_d;
			hdrIdx_q <= hdrIdx_d;
			dest_q <= dest_d;
			remain_q <= remain_d;
			exec_q <= exec_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// pins: enable is low while driving; undriven pins sit on the pull-down
	for (genvar i = 0; i < `SPI_PIN_COUNT; i++) begin : g_pin
		if (isDriven(i)) begin : g_drv
			assign ioOut[i] = drive_q ? traceOf(i, wave_q) : 1'b0;
			assign ioOeN[i] = !drive_q;
		end else begin : g_off
			assign ioOut[i] = 1'b0;
			assign ioOeN[i] = 1'b1;
		end
	end

	assign pinWave = wave_q;
	assign busy = running;
	assign execValid = execValid_q;
	assign execAddr = exec_q;

	////////////////////////////////////////////////////////////////
	// copy buffer: a stalled memory port stops the serial clock
	boot_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.inValid(fifoPush),
		.inReady(fifoReady),
		.inData(fifoInData),
		.outValid(fifoOutValid),
		.outReady(memWrReady),
		.outData(fifoOutData)
	);

	assign memWrValid = fifoOutValid;
	assign memWrAddr = fifoOutData[FW-1:WW];
	assign memWrData = fifoOutData[WW-1:0];
endmodule : spi_flash_boot_reader

// [spi_flash_boot_reader_properties.sv]
// Purpose: port assertions for the flash boot reader
// Assumes: bench runs halfBitDelay = 5
// Notes: repeat counts are tied to that half-bit
`timescale 1ns/1ns
module spi_boot_reader_checker #(
	parameter int ADDR_W = 18
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic bootStart,
	input wire logic [17:0] ioOut,
	input wire logic [17:0] ioOeN,
	input wire logic memWrValid,
	input wire logic memWrReady,
	input wire logic [ADDR_W-1:0] memWrAddr,
	input wire logic [17:0] memWrData,
	input wire logic execValid,
	input wire logic resumeStream,
	input wire logic stopStream,
	input wire logic busy,
	input wire spi_boot_pkg::wave_t pinWave
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence bootTaken;
		!busy && bootStart;
	endsequence
	sequence selStep;
		(ioOut[5] && !ioOeN[5]) [*5];
	endsequence
	a_reset_undriven: assert property (disable iff (1'b0) rst |=> ioOeN == 18'h3ffff && !busy)
		else $error("pins driven after reset");
	a_spare_pins: assert property ((ioOeN | 18'h0002a) == 18'h3ffff && (ioOut & 18'h3ffd5) == 18'h0)
		else $error("spare pin driven");
	a_wave_legal: assert property (!(ioOut[5] && ioOut[3]) && pinWave == {ioOut[5], ioOut[3], ioOut[1]})
		else $error("illegal pin state");
	a_step_hold: assert property ($changed(pinWave) |=> $stable(pinWave) [*4])
		else $error("step shorter than half bit");
	a_boot_select: assert property (bootTaken |=> busy ##0 selStep ##1 !ioOut[5])
		else $error("select sequence wrong");
	a_clk_sel: assert property (ioOut[1] |-> !ioOut[5])
		else $error("clock with select high");
	a_fifo_hold: assert property (memWrValid && !memWrReady |=> memWrValid && $stable(memWrData)
		&& $stable(memWrAddr))
		else $error("memory write not held");
	a_exec_drain: assert property (execValid |-> !memWrValid)
		else $error("exec before buffer drained");
	a_exec_stays: assert property (execValid && !resumeStream && !stopStream |=> execValid)
		else $error("exec dropped early");
	a_chain_cont: assert property (execValid && resumeStream && !stopStream |=> !ioOut[5] [*8])
		else $error("select raised on chaining");
	a_stop_select: assert property (execValid && stopStream |=> ##[0:8] ioOut[5])
		else $error("select not raised on stop");
endmodule : spi_boot_reader_checker
bind spi_flash_boot_reader spi_boot_reader_checker #(.ADDR_W(ADDR_W)) u_spi_boot_reader_checker (
	.clk(clk), .rst(rst), .bootStart(bootStart), .ioOut(ioOut), .ioOeN(ioOeN),
	.memWrValid(memWrValid), .memWrReady(memWrReady), .memWrAddr(memWrAddr),
	.memWrData(memWrData), .execValid(execValid), .resumeStream(resumeStream),
	.stopStream(stopStream), .busy(busy), .pinWave(pinWave));

// [spi_flash_model.sv]
// Purpose: serial flash slave answering one read command
// Assumes: mode 0, data shifted on clock fall
// Notes: released data line shows a toggling pattern
`timescale 1ns/1ns
module spi_flash_model (
	input wire logic clk,
	input wire logic sel,
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	output logic [31:0] rxCmd,
	output logic [7:0] nSel
);
	bit bitMem [0:1023];
	logic sckQ = 1'b0;
	logic selQ = 1'b0;
	logic [5:0] nCmd = 6'h0;
	logic [9:0] pos = 10'h0;
	initial miso = 1'b0;
	initial rxCmd = 32'h0;
	initial nSel = 8'h0;
	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		sckQ <= sck;
		selQ <= sel;
		if (sel) begin
			nCmd <= 6'h0;
			miso <= ~miso;
		end else begin
			if (selQ)
				nSel <= nSel + 8'h1;
			if (sck && !sckQ && nCmd < 6'd32) begin
				rxCmd <= {rxCmd[30:0], mosi};
				nCmd <= nCmd + 6'h1;
				if (nCmd == 6'd31)
					pos <= {rxCmd[5:0], mosi, 3'h0};
			end
			if (!sck && sckQ && nCmd == 6'd32) begin
				miso <= bitMem[pos];
				pos <= pos + 10'h1;
			end else if (nCmd < 6'd32) begin
				miso <= ~miso;
			end
		end
	end
endmodule : spi_flash_model

// [tb_top.sv]
// Purpose: self-checking bench for the flash boot reader
// Assumes: half bit of 5 cycles, an 80 ns link clock
// Notes: streams are written straight into the flash model
`timescale 1ns/1ns
module tb_top;
	import spi_boot_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic bootStart = 1'b0;
	logic coldStart = 1'b1;
	logic [17:0] cmdItem1 = 18'h0;
	logic [17:0] cmdItem2 = 18'h0;
	logic memWrReady = 1'b0;
	logic resumeStream = 1'b0;
	logic stopStream = 1'b0;
	logic [17:0] ioOut, ioOeN, memWrAddr, memWrData, execAddr;
	logic memWrValid, execValid, busy, miso;
	logic [31:0] rxCmd;
	logic [7:0] nSel;
	wave_t pinWave;
	int n_errors = 0;
	int num_checks = 0;
	// undriven pins read low through the weak pull-down
	wire logic [17:0] pinLvl = ioOut & ~ioOeN;
	always #4 clk = ~clk;
	spi_flash_boot_reader u_spi_flash_boot_reader (.clk(clk), .rst(rst), .bootStart(bootStart),
		.coldStart(coldStart), .cmdItem1(cmdItem1), .cmdItem2(cmdItem2),
		.halfBitDelay(16'h0005), .ioIn({miso, pinLvl[16:0]}), .ioOut(ioOut), .ioOeN(ioOeN),
		.memWrValid(memWrValid), .memWrReady(memWrReady), .memWrAddr(memWrAddr),
		.memWrData(memWrData), .execValid(execValid), .execAddr(execAddr),
		.resumeStream(resumeStream), .stopStream(stopStream), .busy(busy), .pinWave(pinWave));
	spi_flash_model u_spi_flash_model (.clk(clk), .sel(pinLvl[5]), .sck(pinLvl[1]),
		.mosi(pinLvl[3]), .miso(miso), .rxCmd(rxCmd), .nSel(nSel));
	////////////////////////////////////////////////////////////////
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic put(inout int p, input logic [17:0] w);
		for (int i = 17; i >= 0; i--) begin
			u_spi_flash_model.bitMem[p] = w[i];
			p++;
		end
	endtask : put
	function automatic logic [17:0] dataWord(int i);
		return 18'h2a5c3 + 18'(i * 1607);
	endfunction : dataWord
	task automatic boot();
		@(posedge clk);
		bootStart <= 1'b1;
		@(posedge clk);
		bootStart <= 1'b0;
	endtask : boot
	task automatic waitExec(logic [17:0] exp);
		for (int k = 0; k < 20000 && execValid !== 1'b1; k++) @(negedge clk);
		chk("execValid", 1, execValid);
		chk("execAddr", exp, execAddr);
	endtask : waitExec
	task automatic stop();
		@(posedge clk);
		stopStream <= 1'b1;
		@(posedge clk);
		stopStream <= 1'b0;
		for (int k = 0; k < 100 && busy !== 1'b0; k++) @(negedge clk);
		chk("select", 2'b10, {ioOut[5], ioOeN[5]});
		chk("busy", 0, busy);
	endtask : stop
	task automatic popAll(int n, logic [17:0] dest, int base);
		int i;
		i = 0;
		for (int k = 0; k < 20000 && i < n; k++) begin
			@(negedge clk);
			if (memWrValid === 1'b1) begin
				chk("memWrAddr", dest + 18'(i), memWrAddr);
				chk("memWrData", dataWord(base + i), memWrData);
				i++;
			end
		end
		chk("words", n, i);
	endtask : popAll
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		@(negedge clk);
		chk("ioOeN", 18'h3ffff, ioOeN);
	endtask : t_reset
	// full buffer must park the link clock; then chain a zero-length sub-stream
	task automatic t_cold();
		int p, hi;
		p = 0;
		put(p, 18'h00010);
		put(p, 18'h00014);
		put(p, 18'h0002a);
		for (int i = 0; i < 20; i++) put(p, dataWord(i));
		put(p, 18'h00040);
		put(p, 18'h00000);
		put(p, 18'h00033);
		boot();
		repeat (20) @(posedge clk);
		boot();
		repeat (5000) @(posedge clk);
		hi = 0;
		repeat (100) @(negedge clk) hi += pinLvl[1];
		chk("parked", 0, hi);
		chk("pending", 1, memWrValid);
		@(posedge clk);
		memWrReady <= 1'b1;
		popAll(20, 18'h010, 0);
		waitExec(18'h02a);
		@(posedge clk);
		resumeStream <= 1'b1;
		@(posedge clk);
		resumeStream <= 1'b0;
		repeat (2) @(posedge clk);
		waitExec(18'h033);
		stop();
		chk("rxCmd", 32'h03000000, rxCmd);
		chk("nSel", 1, nSel);
	endtask : t_cold
	task automatic t_warm();
		int p;
		p = 512;
		put(p, 18'h00005);
		put(p, 18'h00001);
		put(p, 18'h00007);
		put(p, dataWord(40));
		@(posedge clk);
		coldStart <= 1'b0;
		cmdItem1 <= {8'h03, 8'h00, 2'b11};
		cmdItem2 <= {8'h00, 8'h40, 2'b11};
		boot();
		popAll(1, 18'h005, 40);
		waitExec(18'h007);
		stop();
		chk("rxCmd", 32'h03000040, rxCmd);
		chk("nSel", 2, nSel);
	endtask : t_warm
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	initial begin
		#200000;
		n_errors++;
		test_done();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_cold();
		t_warm();
		test_done();
	end
endmodule : tb_top
